// ### inc/mtsq_pkg.sv
// Purpose: constants for the measurement trigger sequencer
// Assumes: 100 MHz mclk_i, APB register access
// Notes: register offsets are byte addresses
// Function
// - Idle when not measuring; sampling indicator lit only during a measurement.
// - Initiate, read-query or measure-query moves idle to wait-for-trigger; only the initiate command exists here.
// - Detected trigger from selected source runs delay, then measurement.
// - Front panel operation keeps the sequencer armed in wait-for-trigger.
// - Auto, immediate and single modes; auto selected after power-on.
// - Auto mode retriggers continuously, readings back to back; here each reading first waits out its completion pulse in DONE.
// - Immediate mode triggers internally on entering wait-for-trigger.
// - Each single key press gives one trigger, one reading or sample count.
// - Trigger-ready indicator lit whenever next trigger can be accepted.
// - External source: each input pulse yields one reading or sample count.
// - External-source indicator lit while external source is enabled.
// - One active-low completion pulse after every completed measurement.
// - External trigger and completion pulse form a switching handshake.
// - Bus mode: trigger command acts exactly like a single-key trigger.
// - All trigger settings volatile, defaults restored at reset.
// - Sample count defaults to one, programmable up to 50000.
// - Trigger count defaults to one before returning to idle.
// - Delay automatic by default, or manual from 0 to 3600 seconds.
package mtsq_pkg;
  localparam logic [7:0] MTSQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] MTSQ_CMD_OFS = 8'h04;
  localparam logic [7:0] MTSQ_SCNT_OFS = 8'h08;
  localparam logic [7:0] MTSQ_TCNT_OFS = 8'h0C;
  localparam logic [7:0] MTSQ_DLY_OFS = 8'h10;
  localparam logic [7:0] MTSQ_ADLY_OFS = 8'h14;
  localparam logic [7:0] MTSQ_STAT_OFS = 8'h18;
  // Control fields
  localparam int MTSQ_SRC_LSB = 0;
  localparam int MTSQ_DAUTO_BIT = 4;
  localparam int MTSQ_REMOTE_BIT = 5;
  // Command strobes
  localparam int MTSQ_CMD_INIT_BIT = 0;
  localparam int MTSQ_CMD_TRG_BIT = 1;
  localparam int MTSQ_CMD_ABORT_BIT = 2;
  typedef enum logic [2:0] {
    MTSQ_SRC_AUTO, MTSQ_SRC_IMM, MTSQ_SRC_SINGLE, MTSQ_SRC_BUS, MTSQ_SRC_EXT
  } mtsq_src_e;
  typedef enum logic [2:0] {
    MTSQ_ST_IDLE, MTSQ_ST_WAIT, MTSQ_ST_DELAY, MTSQ_ST_MEAS, MTSQ_ST_DONE
  } mtsq_state_e;
  localparam logic [15:0] MTSQ_SCNT_MAX = 16'hC350; // 50000
  localparam logic [15:0] MTSQ_SCNT_RST = 16'h0001;
  localparam logic [15:0] MTSQ_TCNT_RST = 16'h0001;
  localparam logic [11:0] MTSQ_DLY_MAX_S = 12'hE10; // 3600 s
  localparam logic [31:0] MTSQ_DLY_RST = 32'h0000_0000;
  localparam logic [31:0] MTSQ_ADLY_RST = 32'h0000_0000;
  localparam int MTSQ_CLK_HZ = 100_000_000;
  localparam int MTSQ_MS_PER_S = 1000;
  // Delay register counts milliseconds
  localparam int MTSQ_TICK_NS = 1_000_000;
  localparam int MTSQ_CLK_NS = 10;
  localparam int MTSQ_TICK_CYC = MTSQ_TICK_NS / MTSQ_CLK_NS;
  localparam logic [31:0] MTSQ_DLY_MAX_MS = 32'(3600 * MTSQ_MS_PER_S);
  localparam logic [31:0] MTSQ_APB_ZERO = 32'h0000_0000;
endpackage

// ### hdl/mtsq_top.sv
// Purpose: trigger sequencer with APB registers and external handshake
// Assumes: single clock, external pins asynchronous
// Notes: measurement engine handshakes via meas_start_o/meas_done_i
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module mtsq_top #(
  parameter int TICK_CYC = mtsq_pkg::MTSQ_TICK_CYC,
  parameter int EXT_MIN_CYC = 4,
  parameter int COMP_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic single_key_i,
  input wire logic external_trigger_input_n_i,
  input wire logic meas_done_i,
  output logic meas_start_o,
  output logic measurement_complete_output_n_o,
  output logic sampling_o,
  output logic trigger_ready_indicator_o,
  output logic external_source_indicator_o
);
  mtsq_pkg::mtsq_state_e state_reg;
  mtsq_pkg::mtsq_src_e src_reg;
  logic dauto_reg;
  logic remote_reg;
  logic [15:0] scnt_reg;
  logic [15:0] tcnt_reg;
  logic [31:0] dly_reg;
  logic [31:0] adly_reg;
  logic [15:0] samp_left_reg;
  logic [15:0] trg_left_reg;
  logic [31:0] dly_left_reg;
  logic [31:0] tick_cnt_reg;
  logic [2:0] ext_sync_reg;
  logic ext_level_reg;
  logic [15:0] ext_wid_reg;
  logic ext_pulse;
  logic [2:0] key_sync_reg;
  logic key_level_reg;
  logic key_pulse;
  logic [15:0] comp_cnt_reg;
  logic wr_en;
  logic init_cmd;
  logic bus_cmd;
  logic abort_cmd;
  logic trigger_ready_indicator_det;
  logic tick;
  logic [31:0] dly_sel;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Zero-wait APB slave
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i && (pstrb_i != 4'h0);
  assign pslverr_o = psel_i && penable_i && !(hit(paddr_i, mtsq_pkg::MTSQ_CTRL_OFS) ||
    hit(paddr_i, mtsq_pkg::MTSQ_CMD_OFS) || hit(paddr_i, mtsq_pkg::MTSQ_SCNT_OFS) ||
    hit(paddr_i, mtsq_pkg::MTSQ_TCNT_OFS) || hit(paddr_i, mtsq_pkg::MTSQ_DLY_OFS) ||
    hit(paddr_i, mtsq_pkg::MTSQ_ADLY_OFS) || hit(paddr_i, mtsq_pkg::MTSQ_STAT_OFS));
  assign init_cmd = wr_en && hit(paddr_i, mtsq_pkg::MTSQ_CMD_OFS) &&
    pwdata_i[mtsq_pkg::MTSQ_CMD_INIT_BIT];
  assign bus_cmd = wr_en && hit(paddr_i, mtsq_pkg::MTSQ_CMD_OFS) &&
    pwdata_i[mtsq_pkg::MTSQ_CMD_TRG_BIT];
  assign abort_cmd = wr_en && hit(paddr_i, mtsq_pkg::MTSQ_CMD_OFS) &&
    pwdata_i[mtsq_pkg::MTSQ_CMD_ABORT_BIT];

  // Settings registers, defaults at reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_reg <= mtsq_pkg::MTSQ_SRC_AUTO;
      dauto_reg <= 1'b1;
      remote_reg <= 1'b0;
      scnt_reg <= mtsq_pkg::MTSQ_SCNT_RST;
      tcnt_reg <= mtsq_pkg::MTSQ_TCNT_RST;
      dly_reg <= mtsq_pkg::MTSQ_DLY_RST;
      adly_reg <= mtsq_pkg::MTSQ_ADLY_RST;
    end else if (wr_en) begin
      if (hit(paddr_i, mtsq_pkg::MTSQ_CTRL_OFS)) begin
        if (pwdata_i[2:0] <= 3'(mtsq_pkg::MTSQ_SRC_EXT)) begin
          src_reg <= mtsq_pkg::mtsq_src_e'(pwdata_i[mtsq_pkg::MTSQ_SRC_LSB +: 3]);
        end
        dauto_reg <= pwdata_i[mtsq_pkg::MTSQ_DAUTO_BIT];
        remote_reg <= pwdata_i[mtsq_pkg::MTSQ_REMOTE_BIT];
      end
      // Out-of-range sample counts are clamped rather than refused
      if (hit(paddr_i, mtsq_pkg::MTSQ_SCNT_OFS)) begin
        if (pwdata_i[15:0] == 16'h0000) begin
          scnt_reg <= mtsq_pkg::MTSQ_SCNT_RST;
        end else if (pwdata_i[31:16] != 16'h0000 || pwdata_i[15:0] > mtsq_pkg::MTSQ_SCNT_MAX) begin
          scnt_reg <= mtsq_pkg::MTSQ_SCNT_MAX;
        end else begin
          scnt_reg <= pwdata_i[15:0];
        end
      end
      if (hit(paddr_i, mtsq_pkg::MTSQ_TCNT_OFS)) begin
        tcnt_reg <= (pwdata_i[15:0] == 16'h0000) ? mtsq_pkg::MTSQ_TCNT_RST : pwdata_i[15:0];
      end
      if (hit(paddr_i, mtsq_pkg::MTSQ_DLY_OFS)) begin
        dly_reg <= (pwdata_i > mtsq_pkg::MTSQ_DLY_MAX_MS) ? mtsq_pkg::MTSQ_DLY_MAX_MS :
          pwdata_i;
      end
      if (hit(paddr_i, mtsq_pkg::MTSQ_ADLY_OFS)) begin
        adly_reg <= (pwdata_i > mtsq_pkg::MTSQ_DLY_MAX_MS) ? mtsq_pkg::MTSQ_DLY_MAX_MS :
          pwdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prdata_o <= mtsq_pkg::MTSQ_APB_ZERO;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        mtsq_pkg::MTSQ_CTRL_OFS: prdata_o <= {26'h0, remote_reg, dauto_reg, 1'b0, src_reg};
        mtsq_pkg::MTSQ_SCNT_OFS: prdata_o <= {16'h0, scnt_reg};
        mtsq_pkg::MTSQ_TCNT_OFS: prdata_o <= {16'h0, tcnt_reg};
        mtsq_pkg::MTSQ_DLY_OFS: prdata_o <= dly_reg;
        mtsq_pkg::MTSQ_ADLY_OFS: prdata_o <= adly_reg;
        mtsq_pkg::MTSQ_STAT_OFS: prdata_o <= {8'h0, trg_left_reg, 5'h0, state_reg};
        default: prdata_o <= mtsq_pkg::MTSQ_APB_ZERO;
      endcase
    end
  end

  // Three-stage synchronisers; decide on stages two and three agreeing
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_sync_reg <= 3'h7;
      ext_level_reg <= 1'b1;
      ext_wid_reg <= 16'h0000;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], external_trigger_input_n_i};
      if (ext_sync_reg[2] == ext_sync_reg[1]) begin
        ext_level_reg <= ext_sync_reg[2];
      end
      // Low-time counter rejects glitches shorter than EXT_MIN_CYC
      if (ext_level_reg) begin
        ext_wid_reg <= 16'h0000;
      end else if (ext_wid_reg != 16'hFFFF) begin
        ext_wid_reg <= ext_wid_reg + 16'h0001;
      end
    end
  end
  assign ext_pulse = !ext_level_reg && (ext_wid_reg == 16'(EXT_MIN_CYC - 1));

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      key_sync_reg <= 3'h0;
      key_level_reg <= 1'b0;
    end else begin
      key_sync_reg <= {key_sync_reg[1:0], single_key_i};
      if (key_sync_reg[2] == key_sync_reg[1]) begin
        key_level_reg <= key_sync_reg[2];
      end
    end
  end
  assign key_pulse = (key_sync_reg[2] == key_sync_reg[1]) && key_sync_reg[2] && !key_level_reg;

  always_comb begin
    unique case (src_reg)
      mtsq_pkg::MTSQ_SRC_AUTO: trigger_ready_indicator_det = 1'b1;
      mtsq_pkg::MTSQ_SRC_IMM: trigger_ready_indicator_det = 1'b1;
      mtsq_pkg::MTSQ_SRC_SINGLE: trigger_ready_indicator_det = key_pulse;
      mtsq_pkg::MTSQ_SRC_BUS: trigger_ready_indicator_det = bus_cmd || key_pulse;
      mtsq_pkg::MTSQ_SRC_EXT: trigger_ready_indicator_det = ext_pulse;
      default: trigger_ready_indicator_det = 1'b0;
    endcase
  end

  assign dly_sel = dauto_reg ? adly_reg : dly_reg;

  // Millisecond tick for the delay
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 32'h0;
    end else if (state_reg != mtsq_pkg::MTSQ_ST_DELAY || tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= mtsq_pkg::MTSQ_ST_IDLE;
      samp_left_reg <= 16'h0;
      trg_left_reg <= 16'h0;
      dly_left_reg <= 32'h0;
    end else if (abort_cmd) begin
      state_reg <= mtsq_pkg::MTSQ_ST_IDLE;
    end else begin
      unique case (state_reg)
        mtsq_pkg::MTSQ_ST_IDLE: begin
          // Front panel stays armed; remote waits for initiate
          if (init_cmd || !remote_reg) begin
            state_reg <= mtsq_pkg::MTSQ_ST_WAIT;
            trg_left_reg <= tcnt_reg;
          end
        end
        mtsq_pkg::MTSQ_ST_WAIT: begin
          if (trigger_ready_indicator_det) begin
            state_reg <= mtsq_pkg::MTSQ_ST_DELAY;
            dly_left_reg <= dly_sel;
            samp_left_reg <= scnt_reg;
          end
        end
        mtsq_pkg::MTSQ_ST_DELAY: begin
          if (dly_left_reg == 32'h0) begin
            state_reg <= mtsq_pkg::MTSQ_ST_MEAS;
          end else if (tick) begin
            dly_left_reg <= dly_left_reg - 32'h1;
          end
        end
        mtsq_pkg::MTSQ_ST_MEAS: begin
          if (meas_done_i) begin
            state_reg <= mtsq_pkg::MTSQ_ST_DONE;
            samp_left_reg <= samp_left_reg - 16'h1;
          end
        end
        mtsq_pkg::MTSQ_ST_DONE: begin
          // Hold until the completion pulse ends, so every reading gets a pulse of its own
          if (comp_cnt_reg != 16'h0) begin
            state_reg <= mtsq_pkg::MTSQ_ST_DONE;
          end else if (samp_left_reg != 16'h0) begin
            state_reg <= mtsq_pkg::MTSQ_ST_MEAS;
          end else if (!remote_reg || trg_left_reg > 16'h1) begin
            state_reg <= mtsq_pkg::MTSQ_ST_WAIT;
            trg_left_reg <= remote_reg ? trg_left_reg - 16'h1 : trg_left_reg;
          end else begin
            state_reg <= mtsq_pkg::MTSQ_ST_IDLE;
            trg_left_reg <= 16'h0;
          end
        end
        default: state_reg <= mtsq_pkg::MTSQ_ST_IDLE;
      endcase
    end
  end

  // Completion pulse, one per reading; the sequencer waits in DONE until it ends,
  // trading some auto-mode rate for a distinct pulse per reading
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_cnt_reg <= 16'h0;
    end else if (state_reg == mtsq_pkg::MTSQ_ST_MEAS && meas_done_i && !abort_cmd) begin
      comp_cnt_reg <= 16'(COMP_CYC);
    end else if (comp_cnt_reg != 16'h0) begin
      comp_cnt_reg <= comp_cnt_reg - 16'h1;
    end
  end

  // Completion pin idles high
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      measurement_complete_output_n_o <= 1'b1;
    end else begin
      measurement_complete_output_n_o <= (comp_cnt_reg == 16'h0);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sampling_o <= 1'b0;
    end else begin
      sampling_o <= (state_reg == mtsq_pkg::MTSQ_ST_MEAS);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trigger_ready_indicator_o <= 1'b0;
    end else begin
      trigger_ready_indicator_o <= (state_reg == mtsq_pkg::MTSQ_ST_WAIT);
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      external_source_indicator_o <= 1'b0;
    end else begin
      external_source_indicator_o <= (src_reg == mtsq_pkg::MTSQ_SRC_EXT);
    end
  end

  // Start pulse matches the state change into MEAS, except when an abort arrives in the same cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meas_start_o <= 1'b0;
    end else begin
      meas_start_o <= (state_reg == mtsq_pkg::MTSQ_ST_DELAY && dly_left_reg == 32'h0) ||
        (state_reg == mtsq_pkg::MTSQ_ST_DONE && samp_left_reg != 16'h0 &&
        comp_cnt_reg == 16'h0);
    end
  end
endmodule

// ### bench/mtsq_chk.sv
// Purpose: port timing checks for the trigger sequencer
// Assumes: aligned APB addresses, one clock domain
// Notes: bound into mtsq_top, COMP_CYC handed on
`timescale 1ns/10ps
module mtsq_chk #(
  parameter int COMP_CYC = 50
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic meas_done_i,
  input wire logic meas_start_o,
  input wire logic measurement_complete_output_n_o,
  input wire logic sampling_o,
  input wire logic trigger_ready_indicator_o,
  input wire logic external_source_indicator_o
);
  logic [15:0] low_cnt_reg;
  // Counts low cycles of the completion pulse
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_reg <= 16'h0000;
    end else begin
      low_cnt_reg <= measurement_complete_output_n_o ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  comp_width_a: assert property ($rose(measurement_complete_output_n_o) |->
    low_cnt_reg == COMP_CYC) else $error("completion pulse width wrong");
  comp_cause_a: assert property ($fell(measurement_complete_output_n_o) |->
    $past(meas_done_i, 2)) else $error("completion pulse without finished reading");
  start_pulse_a: assert property (meas_start_o |=> !meas_start_o)
    else $error("start pulse longer than one cycle");
  samp_start_a: assert property (meas_start_o |-> ##[0:2] sampling_o)
    else $error("sampling indicator dark during reading");
  ready_excl_a: assert property (!(trigger_ready_indicator_o && sampling_o))
    else $error("ready and sampling lit together");
  ext_ind_a: assert property (psel_i && penable_i && pwrite_i && paddr_i == 8'h00 &&
    pstrb_i != 4'h0 |-> ##2 (external_source_indicator_o == ($past(pwdata_i[2:0], 2) == 3'h4)))
    else $error("external indicator does not follow source");
  cmd_zero_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 8'h04 |->
    prdata_o == 32'h0000_0000) else $error("command register read not zero");
  bad_addr_a: assert property (psel_i && penable_i |-> pready_o &&
    (pslverr_o == (paddr_i > 8'h18))) else $error("slave error wrong");
  comp_c: cover property ($fell(measurement_complete_output_n_o));
  ext_c: cover property (meas_start_o && external_source_indicator_o);
  err_c: cover property (psel_i && penable_i && pslverr_o);
endmodule
bind mtsq_top mtsq_chk #(.COMP_CYC(COMP_CYC)) mtsq_chk_inst (.*);

// ### bench/mtsq_partner.sv
// Purpose: switching equipment and measurement engine stand-in
// Assumes: engine answers each start after three cycles
// Notes: trigger line idles high as a pulled-up input would
`timescale 1ns/10ps
module mtsq_partner (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic fire_i,
  input wire logic [3:0] width_i,
  input wire logic meas_start_i,
  input wire logic complete_n_i,
  output logic external_trigger_input_n_o,
  output logic meas_done_o,
  output logic [7:0] handshakes_o
);
  logic [2:0] done_sr_reg;
  logic [3:0] cnt_reg;
  logic [1:0] st_reg;
  assign meas_done_o = done_sr_reg[2];
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_sr_reg <= 3'h0;
    end else begin
      done_sr_reg <= {done_sr_reg[1:0], meas_start_i};
    end
  end
  // A new fire abandons a wait that never got its answer
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= 2'h0;
      cnt_reg <= 4'h0;
      external_trigger_input_n_o <= 1'b1;
      handshakes_o <= 8'h00;
    end else if (fire_i && st_reg != 2'h1) begin
      external_trigger_input_n_o <= 1'b0;
      cnt_reg <= width_i;
      st_reg <= 2'h1;
    end else if (st_reg == 2'h1) begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h1) begin
        external_trigger_input_n_o <= 1'b1;
        st_reg <= 2'h2;
      end
    end else if (st_reg == 2'h2 && !complete_n_i) begin
      st_reg <= 2'h0;
      handshakes_o <= handshakes_o + 8'h01;
    end
  end
endmodule

// ### bench/measurement_trigger_sequencer_tb.sv
// Purpose: directed test of the trigger sequencer over APB and pins
// Assumes: TICK_CYC shortened to 10 cycles per millisecond
// Notes: engine and switching side come from mtsq_partner
`timescale 1ns/10ps
module measurement_trigger_sequencer_tb;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, key = 1'b0, fire = 1'b0, comp_q;
  logic [7:0] paddr = 8'h00, hs;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF, width = 4'h0;
  logic pready, pslverr, ext_n, done, start, comp_n, samp, rdy, ext_ind, err;
  int fails = 0, n_compared = 0, n_start = 0, n_comp = 0, cyc = 0, base, t0;
  always #5 mclk_i = ~mclk_i;
  mtsq_top #(.TICK_CYC(10)) mtsq_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .single_key_i(key), .external_trigger_input_n_i(ext_n),
    .meas_done_i(done), .meas_start_o(start), .measurement_complete_output_n_o(comp_n),
    .sampling_o(samp), .trigger_ready_indicator_o(rdy), .external_source_indicator_o(ext_ind));
  mtsq_partner mtsq_partner_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .fire_i(fire),
    .width_i(width), .meas_start_i(start), .complete_n_i(comp_n), .external_trigger_input_n_o(ext_n),
    .meas_done_o(done), .handshakes_o(hs));
  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    comp_q <= comp_n;
    if (start === 1'b1) n_start <= n_start + 1;
    if (comp_q === 1'b1 && comp_n === 1'b0) n_comp <= n_comp + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1) @(posedge mclk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  task automatic pulse(input logic [3:0] w);
    @(posedge mclk_i);
    width <= w;
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
  endtask
  initial begin
    wt(10);
    reset_n_i <= 1'b1;
    rdc("ctrl", mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0010);
    rdc("samples", mtsq_pkg::MTSQ_SCNT_OFS, 32'h0000_0001);
    rdc("triggers", mtsq_pkg::MTSQ_TCNT_OFS, 32'h0000_0001);
    rdc("delay", mtsq_pkg::MTSQ_DLY_OFS, 32'h0000_0000);
    rdc("cmd", mtsq_pkg::MTSQ_CMD_OFS, 32'h0000_0000);
    rdc("unmapped", 8'h1C, 32'h0000_0000);
    chk("slverr", 32'h1, err);
    wt(300);
    chk("auto starts", 32'h1, n_start >= 2);
    chk("auto completions", 32'h1, n_comp >= 2);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0012);
    apb(1'b1, mtsq_pkg::MTSQ_SCNT_OFS, 32'h0000_0003);
    wt(300);
    base = n_start;
    wt(100);
    chk("no key no start", base, n_start);
    chk("armed", 32'h1, rdy);
    key <= 1'b1;
    wt(3);
    key <= 1'b0;
    wt(400);
    chk("key readings", base + 3, n_start);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0013);
    apb(1'b1, mtsq_pkg::MTSQ_SCNT_OFS, 32'h0000_0001);
    wt(100);
    base = n_start;
    apb(1'b1, mtsq_pkg::MTSQ_CMD_OFS, 32'h0000_0002);
    wt(300);
    chk("bus trigger", base + 1, n_start);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0014);
    wt(3);
    chk("ext indicator", 32'h1, ext_ind);
    base = n_start;
    pulse(4'h2);
    wt(100);
    chk("short pulse", base, n_start);
    pulse(4'h8);
    wt(300);
    chk("ext reading", base + 1, n_start);
    chk("handshake", 32'h1, hs);
    apb(1'b1, mtsq_pkg::MTSQ_TCNT_OFS, 32'h0000_0002);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0033);
    apb(1'b1, mtsq_pkg::MTSQ_CMD_OFS, 32'h0000_0004);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0031);
    base = n_start;
    wt(100);
    chk("idle holds", base, n_start);
    apb(1'b1, mtsq_pkg::MTSQ_CMD_OFS, 32'h0000_0001);
    wt(400);
    chk("two triggers", base + 2, n_start);
    apb(1'b0, mtsq_pkg::MTSQ_STAT_OFS, 32'h0000_0000);
    chk("back to idle", 32'h0, rd[2:0]);
    chk("not ready", 32'h0, rdy);
    apb(1'b1, mtsq_pkg::MTSQ_DLY_OFS, 32'h0000_0003);
    apb(1'b1, mtsq_pkg::MTSQ_CTRL_OFS, 32'h0000_0021);
    base = n_start;
    apb(1'b1, mtsq_pkg::MTSQ_CMD_OFS, 32'h0000_0001);
    t0 = cyc;
    for (int i = 0; i < 200 && n_start == base; i++) @(posedge mclk_i);
    chk("delay run", 32'h1, (cyc - t0) >= 30 && (cyc - t0) < 50);
    wt(400);
    apb(1'b1, mtsq_pkg::MTSQ_SCNT_OFS, 32'd60000);
    rdc("sample clamp", mtsq_pkg::MTSQ_SCNT_OFS, 32'h0000_C350);
    tally_and_finish();
  end
endmodule
